// [common/gis_pkg.sv]
package gis_pkg;

    // Register indices; the byte address on APB is four times the index
    localparam logic [9:0] IDX_CTRL1 = 10'h002; // Global control, first word
    localparam logic [9:0] IDX_CTRL2 = 10'h004; // Global control, second word
    localparam logic [9:0] IDX_PIN_FSEL = 10'h00A; // general_pin_function_select
    localparam logic [9:0] IDX_SUMMARY = 10'h010; // global_irq_summary
    localparam logic [9:0] IDX_SUMMARY_EN = 10'h012; // global_irq_summary_enable
    localparam logic [9:0] IDX_LIVE = 10'h014; // global_live_status
    localparam logic [9:0] IDX_LATCHED = 10'h016; // global_latched_status
    localparam logic [9:0] IDX_LATCHED_EN = 10'h018; // global_latched_status_enable
    localparam logic [9:0] IDX_READBACK = 10'h01C; // general_pin_readback

    // Control word one fields
    localparam int CTRL1_IRQ_IDLE_BIT = 14; // irq_pin_idle_mode
    localparam int CTRL1_ERR_SRC_BIT = 6; // error_insert_source_sel
    localparam int CTRL1_PM_MODE_LSB = 4; // pm_update_mode, two bits
    localparam int CTRL1_PM_REQ_BIT = 3; // perf_update_request
    localparam int CTRL1_CLR_READ_BIT = 2; // latched_clear_on_read
    localparam logic [15:0] CTRL1_MASK = 16'h407C; // Writable bits
    // Control word two fields
    localparam int CTRL2_REF_OUT_BIT = 9; // ref8k_output_sel
    localparam int CTRL2_REF_IN_BIT = 8; // ref8k_input_sel
    localparam logic [15:0] CTRL2_MASK = 16'h0300; // Writable bits

    // Summary and status fields
    localparam int SUM_GLOBAL_BIT = 0; // global_summary_flag
    localparam int SUM_TX_BIT = 1; // tx_sysif_summary_flag
    localparam int SUM_PORT_LSB = 4; // port_summary_flag[4:1]
    localparam logic [15:0] SUMMARY_EN_MASK = 16'h00F3; // Writable enables
    localparam int LIVE_UPDATE_BIT = 0; // update_complete_live
    localparam int LIVE_UNLOCK_BIT = 1; // pll_unlock_live
    localparam int LAT_UPDATE_BIT = 0; // update_complete_latched
    localparam int LAT_UNLOCK_BIT = 1; // pll_unlock_latched
    localparam int LAT_ONESEC_BIT = 2; // one_second_latched
    localparam int LAT_REFCLK_BIT = 3; // adapter_refclk_activity_latched
    localparam int LAT_REF8K_BIT = 4; // ref8k_activity_latched
    localparam logic [15:0] LATCHED_EN_MASK = 16'h0007; // Writable enables

    // Pin function codes
    localparam logic [1:0] FSEL_INPUT = 2'h0;
    localparam logic [1:0] FSEL_STATUS = 2'h1;
    localparam logic [1:0] FSEL_LOW = 2'h2;
    localparam logic [1:0] FSEL_HIGH = 2'h3;
    localparam logic [1:0] PM_MODE_PIN = 2'h1; // Update trigger on pin 8

    // Fixed sizes
    localparam int PIN_N = 8; // General-purpose pins
    localparam int PORT_N = 4; // Line ports
    localparam int PLL_N = 3; // Adapter PLLs
    localparam int TX_N = 2; // Transmit interface latched bits
    localparam int SYNC_W = 9; // Eight pins and the adapter clock

    // Timing
    localparam longint CLK_HZ = 64'd40000000; // clk_sys rate
    localparam longint ONE_SECOND_MS = 64'd1000; // Tick period in ms
    localparam longint ONE_SEC_CYCLES = ONE_SECOND_MS * CLK_HZ / 64'd1000;
    localparam int TICK_W = 26; // Holds one second of cycles

    // APB request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } gis_apb_req_t;

endpackage

// [src/gis_sync3.sv]
`timescale 1ns/1ps
module gis_sync3 (
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic [gis_pkg::SYNC_W-1:0] async_in, // Raw pin levels
    output logic [gis_pkg::SYNC_W-1:0] level_q, // Filtered level
    output logic [gis_pkg::SYNC_W-1:0] change_q // One-cycle pulse on change
);
    import gis_pkg::*;

    logic [SYNC_W-1:0] s1_q; // First stage, read only by s2
    logic [SYNC_W-1:0] s2_q; // Second stage
    logic [SYNC_W-1:0] s3_q; // Third stage

    // Three-stage chain
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end
        else
        begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Accept a level only once two stages agree, so a metastable sample never counts
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            level_q <= '0;
            change_q <= '0;
        end
        else
        begin
            for (int i = 0; i < SYNC_W; i++)
            begin
                change_q[i] <= (s2_q[i] == s3_q[i]) && (s3_q[i] != level_q[i]);
                if (s2_q[i] == s3_q[i])
                    level_q[i] <= s3_q[i];
            end
        end
    end

endmodule // gis_sync3

// [src/gis_top.sv]
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module gis_top #(
    parameter int unsigned ONE_SEC_CYCLES = 32'(gis_pkg::ONE_SEC_CYCLES) // Cycles per tick
) (
    input wire logic clk_sys, // 40 MHz system clock
    input wire logic rst_n, // Async reset, active low
    input wire gis_pkg::gis_apb_req_t apb_req, // APB request
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error for unmapped address
    input wire logic [gis_pkg::PIN_N-1:0] gpio_i, // Pin levels, pin 8 in bit 7
    output logic [gis_pkg::PIN_N-1:0] gpio_o, // Pin drive values
    output logic [gis_pkg::PIN_N-1:0] gpio_oe, // Pin drive enables
    input wire logic [gis_pkg::PORT_N-1:0] port_status_a, // Per-port A status chosen by port_status_a_sel
    input wire logic [gis_pkg::PORT_N-1:0] port_status_b, // Per-port B status chosen by port_status_b_sel
    input wire logic [gis_pkg::PORT_N-1:0] port_irq_any, // Per-port interrupt status OR
    input wire logic [gis_pkg::TX_N-1:0] tx_sysif_latched, // Transmit latched status
    input wire logic [gis_pkg::TX_N-1:0] tx_sysif_enable, // Transmit status enables
    input wire logic [gis_pkg::PLL_N-1:0] pll_locked, // clock_adapter PLL lock levels
    input wire logic adapter_ref_clock_pin, // Adapter reference clock pin
    input wire logic [gis_pkg::PORT_N-1:0] port_update_done, // Per-port update finished
    input wire logic [gis_pkg::PORT_N-1:0] port_global_update_mode, // Port follows global update
    input wire logic ref8k_out_sig, // Global 8k reference to drive on pin 2
    output logic perf_update_request, // Global update request to ports
    output logic error_insert_in, // Error-insert level from pin 6
    output logic ref8k_in, // 8k reference from pin 4, low if not selected
    output logic int_n_o, // Interrupt pin value
    output logic int_n_oe // Interrupt pin drive enable
);
    import gis_pkg::*;

    // Software state
    logic [15:0] ctrl1_q; // First control word
    logic [15:0] ctrl2_q; // Second control word
    logic [15:0] fsel_q; // Pin function selects
    logic [15:0] sum_en_q; // Summary enables
    logic [15:0] lat_en_q; // Latched status enables
    logic [15:0] latched_q; // Latched status flags
    logic [31:0] prdata_q; // Read data captured in setup phase
    logic [TICK_W-1:0] tick_cnt_q; // One-second divider
    logic one_sec_q; // One-cycle tick pulse
    logic unlock_live_q; // Previous live unlock
    logic update_live_q; // Previous live update-complete
    logic irq_active_q; // Registered interrupt condition
    logic [SYNC_W-1:0] pin_level; // Synchronised pin levels
    logic [SYNC_W-1:0] pin_change; // Change pulses

    // Derived signals
    logic [9:0] acc_idx; // Word index of current access
    logic acc_mapped; // Address hits a register
    logic wr_acc; // Write taking effect now
    logic rd_acc; // Read taking effect now
    logic pll_unlock_live; // Any PLL unlocked
    logic update_complete_live; // All enabled ports updated
    logic [15:0] summary; // Global summary word
    logic [15:0] live; // Live status word
    logic [15:0] lat_set; // Set events this cycle
    logic [15:0] lat_clr; // Clear requests this cycle
    logic [1:0] pm_mode; // Update mode field
    logic [15:0] readback; // Pin readback word

    // Map a word index to decode validity
    function automatic logic is_mapped(input logic [9:0] idx);
        if (idx == IDX_CTRL1) return 1'b1;
        else if (idx == IDX_CTRL2) return 1'b1;
        else if (idx == IDX_PIN_FSEL) return 1'b1;
        else if (idx == IDX_SUMMARY) return 1'b1;
        else if (idx == IDX_SUMMARY_EN) return 1'b1;
        else if (idx == IDX_LIVE) return 1'b1;
        else if (idx == IDX_LATCHED) return 1'b1;
        else if (idx == IDX_LATCHED_EN) return 1'b1;
        else if (idx == IDX_READBACK) return 1'b1;
        else return 1'b0;
    endfunction

    // Drive value and enable for one pin from its code; status feeds code one
    function automatic logic [1:0] pin_drive(input logic [1:0] code, input logic status);
        case (code)
            FSEL_STATUS: return {1'b1, status};
            FSEL_LOW: return 2'b10;
            FSEL_HIGH: return 2'b11;
            default: return 2'b00;
        endcase
    endfunction

    // Pin and adapter clock synchroniser
    gis_sync3 u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .async_in({adapter_ref_clock_pin, gpio_i}),
        .level_q(pin_level),
        .change_q(pin_change)
    );

    // APB decode; misaligned addresses count as unmapped
    assign acc_idx = apb_req.paddr[11:2];
    assign acc_mapped = is_mapped(acc_idx) && (apb_req.paddr[1:0] == 2'b00);
    assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite && acc_mapped;
    assign rd_acc = apb_req.psel && apb_req.penable && !apb_req.pwrite && acc_mapped;
    assign pready = apb_req.psel && apb_req.penable;
    assign pslverr = apb_req.psel && apb_req.penable && !acc_mapped;
    assign prdata = prdata_q;

    // Live status
    assign pm_mode = ctrl1_q[CTRL1_PM_MODE_LSB +: 2];
    assign pll_unlock_live = !(&pll_locked);
    assign perf_update_request = (pm_mode == 2'h0) ? ctrl1_q[CTRL1_PM_REQ_BIT] :
        (pm_mode == PM_MODE_PIN) ? pin_level[7] : 1'b1;
    // Empty port set leaves only the request term
    assign update_complete_live = perf_update_request && (&(port_update_done | ~port_global_update_mode));
    assign live = {14'h0000, pll_unlock_live, update_complete_live};

    // Summary word
    always_comb
    begin
        summary = 16'h0000;
        summary[SUM_GLOBAL_BIT] = |(latched_q & lat_en_q);
        summary[SUM_TX_BIT] = |(tx_sysif_latched & tx_sysif_enable);
        summary[SUM_PORT_LSB +: PORT_N] = port_irq_any;
    end

    // Pin-borrowing outputs
    assign error_insert_in = ctrl1_q[CTRL1_ERR_SRC_BIT] ? pin_level[5] : 1'b0;
    assign ref8k_in = ctrl2_q[CTRL2_REF_IN_BIT] ? pin_level[3] : 1'b0;
    assign readback = {8'h00, pin_level[PIN_N-1:0]};

    // Latched set events; edges use the previous-cycle live values
    always_comb
    begin
        lat_set = 16'h0000;
        lat_set[LAT_UPDATE_BIT] = update_complete_live && !update_live_q;
        lat_set[LAT_UNLOCK_BIT] = pll_unlock_live && !unlock_live_q;
        lat_set[LAT_ONESEC_BIT] = one_sec_q;
        lat_set[LAT_REFCLK_BIT] = pin_change[8];
        lat_set[LAT_REF8K_BIT] = pin_change[3] && ctrl2_q[CTRL2_REF_IN_BIT];
    end

    // Clear by writing ones, or on read only the bits the reader was shown, so a later set is not lost
    always_comb
    begin
        lat_clr = 16'h0000;
        if (acc_idx == IDX_LATCHED)
        begin
            if (ctrl1_q[CTRL1_CLR_READ_BIT] && rd_acc)
                lat_clr = prdata_q[15:0] & 16'h001F;
            else if (!ctrl1_q[CTRL1_CLR_READ_BIT] && wr_acc)
                lat_clr = apb_req.pwdata[15:0] & 16'h001F;
        end
    end

    // Latched flags; a set in the clear cycle wins
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            latched_q <= 16'h0000;
        else
            latched_q <= (latched_q & ~lat_clr) | lat_set;
    end

    // Edge history of live bits
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            unlock_live_q <= 1'b0;
            update_live_q <= 1'b0;
        end
        else
        begin
            unlock_live_q <= pll_unlock_live;
            update_live_q <= update_complete_live;
        end
    end

    // One-second divider; free-running from clk_sys, not from the 8k reference
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_cnt_q <= '0;
            one_sec_q <= 1'b0;
        end
        else if (tick_cnt_q == TICK_W'(ONE_SEC_CYCLES - 1))
        begin
            tick_cnt_q <= '0;
            one_sec_q <= 1'b1;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_q + TICK_W'(1);
            one_sec_q <= 1'b0;
        end
    end

    // Register writes; masks keep unused bits at zero
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl1_q <= 16'h0000;
            ctrl2_q <= 16'h0000;
            fsel_q <= 16'h0000;
            sum_en_q <= 16'h0000;
            lat_en_q <= 16'h0000;
        end
        else if (wr_acc)
        begin
            if (acc_idx == IDX_CTRL1)
                ctrl1_q <= apb_req.pwdata[15:0] & CTRL1_MASK;
            else if (acc_idx == IDX_CTRL2)
                ctrl2_q <= apb_req.pwdata[15:0] & CTRL2_MASK;
            else if (acc_idx == IDX_PIN_FSEL)
                fsel_q <= apb_req.pwdata[15:0];
            else if (acc_idx == IDX_SUMMARY_EN)
                sum_en_q <= apb_req.pwdata[15:0] & SUMMARY_EN_MASK;
            else if (acc_idx == IDX_LATCHED_EN)
                lat_en_q <= apb_req.pwdata[15:0] & LATCHED_EN_MASK;
        end
    end

    // Read data captured in the setup phase so it comes from a flop
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            prdata_q <= 32'h00000000;
        else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite)
        begin
            if (acc_idx == IDX_CTRL1)
                prdata_q <= {16'h0000, ctrl1_q};
            else if (acc_idx == IDX_CTRL2)
                prdata_q <= {16'h0000, ctrl2_q};
            else if (acc_idx == IDX_PIN_FSEL)
                prdata_q <= {16'h0000, fsel_q};
            else if (acc_idx == IDX_SUMMARY)
                prdata_q <= {16'h0000, summary};
            else if (acc_idx == IDX_SUMMARY_EN)
                prdata_q <= {16'h0000, sum_en_q};
            else if (acc_idx == IDX_LIVE)
                prdata_q <= {16'h0000, live};
            else if (acc_idx == IDX_LATCHED)
                prdata_q <= {16'h0000, latched_q};
            else if (acc_idx == IDX_LATCHED_EN)
                prdata_q <= {16'h0000, lat_en_q};
            else if (acc_idx == IDX_READBACK)
                prdata_q <= {16'h0000, readback};
            else
                prdata_q <= 32'h00000000;
        end
    end

    // Pin drivers, registered; borrowed pins override their codes
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gpio_o <= '0;
            gpio_oe <= '0;
        end
        else
        begin
            for (int i = 0; i < PIN_N; i++)
            begin
                logic [1:0] drv;
                drv = pin_drive(fsel_q[2*i +: 2], (i % 2 == 0) ? port_status_a[i/2] : port_status_b[i/2]);
                if (i == 7 && pm_mode == PM_MODE_PIN)
                    drv = 2'b00;
                if (i == 5 && ctrl1_q[CTRL1_ERR_SRC_BIT])
                    drv = 2'b00;
                if (i == 3 && ctrl2_q[CTRL2_REF_IN_BIT])
                    drv = 2'b00;
                if (i == 1 && ctrl2_q[CTRL2_REF_OUT_BIT])
                    drv = {1'b1, ref8k_out_sig};
                gpio_oe[i] <= drv[1];
                gpio_o[i] <= drv[0];
            end
        end
    end

    // Interrupt pin, registered
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            irq_active_q <= 1'b0;
        else
            irq_active_q <= |(summary & sum_en_q);
    end
    assign int_n_o = !irq_active_q;
    assign int_n_oe = irq_active_q || ctrl1_q[CTRL1_IRQ_IDLE_BIT];

    // Checks
    sequence s_no_clear;
        !(apb_req.psel && apb_req.penable && acc_idx == IDX_LATCHED);
    endsequence
    property p_int_pin;
        @(posedge clk_sys) disable iff (!rst_n)
        (|(summary & sum_en_q)) |=> (!int_n_o && int_n_oe);
    endproperty
    a_int_pin: assert property (p_int_pin) else $error("interrupt pin not low");
    property p_int_idle;
        @(posedge clk_sys) disable iff (!rst_n)
        !(|(summary & sum_en_q)) |=> (int_n_o && (int_n_oe == ctrl1_q[CTRL1_IRQ_IDLE_BIT]));
    endproperty
    a_int_idle: assert property (p_int_idle) else $error("idle interrupt pin wrong");
    property p_unlock_latch;
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(pll_unlock_live) |-> ##1 latched_q[LAT_UNLOCK_BIT];
    endproperty
    a_unlock_latch: assert property (p_unlock_latch) else $error("unlock edge not latched");
    property p_update_latch;
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(update_complete_live) |=> latched_q[LAT_UPDATE_BIT];
    endproperty
    a_update_latch: assert property (p_update_latch) else $error("update edge not latched");
    property p_sticky;
        @(posedge clk_sys) disable iff (!rst_n)
        (latched_q[LAT_ONESEC_BIT] ##0 s_no_clear) |=> latched_q[LAT_ONESEC_BIT];
    endproperty
    a_sticky: assert property (p_sticky) else $error("latched bit lost");
    property p_pin8_input;
        @(posedge clk_sys) disable iff (!rst_n)
        (pm_mode == PM_MODE_PIN) [*2] |-> !gpio_oe[7];
    endproperty
    a_pin8_input: assert property (p_pin8_input) else $error("pin 8 driven in pin mode");
    property p_pin1_high;
        @(posedge clk_sys) disable iff (!rst_n)
        (fsel_q[1:0] == FSEL_HIGH) |=> (gpio_oe[0] && gpio_o[0]);
    endproperty
    a_pin1_high: assert property (p_pin1_high) else $error("pin 1 not high");
    property p_onesec;
        @(posedge clk_sys) disable iff (!rst_n)
        (tick_cnt_q == TICK_W'(ONE_SEC_CYCLES - 1)) |-> ##2 latched_q[LAT_ONESEC_BIT];
    endproperty
    a_onesec: assert property (p_onesec) else $error("one-second tick not latched");
    property p_port_summary;
        @(posedge clk_sys) disable iff (!rst_n)
        (|(port_irq_any & sum_en_q[SUM_PORT_LSB +: PORT_N])) |=> !int_n_o;
    endproperty
    a_port_summary: assert property (p_port_summary) else $error("enabled port interrupt not on pin");
    property p_update_zero;
        @(posedge clk_sys) disable iff (!rst_n)
        !perf_update_request |-> !live[LIVE_UPDATE_BIT];
    endproperty
    a_update_zero: assert property (p_update_zero) else $error("update complete without request");

endmodule // gis_top

// [verification/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    import gis_pkg::*;
    localparam int unsigned TICK = 50; // Short one-second period keeps the run brief
    logic clk_sys, rst_n, pready, pslverr, ref_clk, ref8k_out, pm_req, err_in, ref8k_in, int_n_o, int_n_oe, err_q;
    gis_apb_req_t apb_req; // Bus request driven by the tasks
    logic [31:0] prdata, rd; // Read data and last captured word
    logic [7:0] gpio_i, gpio_o, gpio_oe, ext_pins, exp8; // Pin wires and outside drivers
    logic [3:0] st_a, st_b, irq_any, upd_done, upd_mode; // Per-port inputs
    logic [1:0] tx_lat, tx_en; // Transmit interface status
    logic [2:0] pll_locked; // Adapter lock levels
    int fail_count, n_tests; // Verdict counters
    logic [11:0] reset_addrs [7] = '{12'h008, 12'h010, 12'h028, 12'h040, 12'h048, 12'h050, 12'h060}; // Reset-zero words
    // Pin wire: the device wins where it drives, the outside world elsewhere
    assign gpio_i = (gpio_oe & gpio_o) | (~gpio_oe & ext_pins);
    gis_top #(.ONE_SEC_CYCLES(TICK)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .apb_req(apb_req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe(gpio_oe),
        .port_status_a(st_a), .port_status_b(st_b), .port_irq_any(irq_any), .tx_sysif_latched(tx_lat),
        .tx_sysif_enable(tx_en), .pll_locked(pll_locked), .adapter_ref_clock_pin(ref_clk),
        .port_update_done(upd_done), .port_global_update_mode(upd_mode), .ref8k_out_sig(ref8k_out),
        .perf_update_request(pm_req), .error_insert_in(err_in), .ref8k_in(ref8k_in), .int_n_o(int_n_o),
        .int_n_oe(int_n_oe));
    // Free-running 40 MHz clock
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // One compare, counted; mismatch printed at once
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask
    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
        @(posedge clk_sys);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
        @(posedge clk_sys);
        apb_req.penable <= 1'b1;
        do
            @(posedge clk_sys);
        while (pready !== 1'b1); // No timeout; a wait that never sees pready ends only at the watchdog
        rd = prdata;
        err_q = pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask
    // Masked register read against an expected word
    task automatic rdc(input string name, input logic [11:0] addr, input logic [31:0] exp, input logic [31:0] m);
        apb(1'b0, addr, 32'h0);
        chk(name, exp, rd & m);
    endtask
    // Let n edges pass, then sample at the falling edge where outputs are settled
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic tally_and_finish();
        if (fail_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Watchdog well beyond the few hundred cycles the sequence needs
    initial
    begin
        #(25 * 20000);
        fail_count++;
        tally_and_finish();
    end
    // Main sequence
    initial
    begin
        {rst_n, ref_clk, ref8k_out, st_a, st_b, irq_any, upd_done, upd_mode, tx_lat, tx_en, ext_pins} = '0;
        apb_req = '0;
        pll_locked = 3'h7;
        fail_count = 0;
        n_tests = 0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        chk("int_n_o", 1'b1, int_n_o);
        chk("int_n_oe", 1'b0, int_n_oe);
        // Control, enable, live and summary words all start cleared
        foreach (reset_addrs[i])
            rdc("reset_word", reset_addrs[i], 32'h0, '1);
        st_a <= 4'hA;
        st_b <= 4'h3;
        ext_pins <= 8'h96;
        // Every function code on all eight pins
        for (int c = 0; c < 4; c++)
        begin
            apb(1'b1, 12'h028, {16'h0, {8{c[1:0]}}});
            cyc(6);
            for (int p = 0; p < 8; p++)
                exp8[p] = (c == 0) ? ext_pins[p] : (c == 1) ? (p[0] ? st_b[p / 2] : st_a[p / 2]) : c[0];
            chk("gpio_oe", (c == 0) ? 8'h00 : 8'hFF, gpio_oe);
            chk("gpio_pins", exp8, gpio_i);
            rdc("readback", 12'h070, exp8, '1);
        end
        // Overrides on pins 8, 6, 4 and 2 with all pins coded high
        apb(1'b1, 12'h008, 32'h0050);
        apb(1'b1, 12'h010, 32'h0300);
        ext_pins <= 8'hA8;
        cyc(6);
        chk("gpio_oe", 8'h57, gpio_oe);
        chk("pin2_ref_out", 1'b0, gpio_o[1]);
        chk("update_req_pin", 1'b1, pm_req);
        chk("err_insert", 1'b1, err_in);
        chk("ref8k_in", 1'b1, ref8k_in);
        apb(1'b1, 12'h058, 32'h1F);
        ext_pins <= 8'hA0;
        ref_clk <= 1'b1;
        cyc(6);
        rdc("activity_latched", 12'h058, 32'h18, 32'h18);
        // Port and transmit summaries
        irq_any <= 4'h5;
        tx_lat <= 2'h2;
        tx_en <= 2'h1;
        cyc(2);
        chk("int_n_o", 1'b1, int_n_o);
        rdc("summary", 12'h040, 32'h50, 32'hF2);
        apb(1'b1, 12'h048, 32'hFFFF);
        rdc("summary_en", 12'h048, 32'hF3, '1);
        cyc(2);
        chk("int_n_o", 1'b0, int_n_o);
        chk("int_n_oe", 1'b1, int_n_oe);
        @(posedge clk_sys);
        irq_any <= 4'h0;
        tx_en <= 2'h2;
        rdc("summary", 12'h040, 32'h02, 32'hF2);
        tx_lat <= 2'h0;
        cyc(2);
        chk("int_n_o", 1'b1, int_n_o);
        chk("int_n_oe", 1'b0, int_n_oe);
        apb(1'b1, 12'h008, 32'h4000);
        cyc(1);
        chk("int_n_oe", 1'b1, int_n_oe);
        // Update-complete chain and lock loss
        @(posedge clk_sys);
        upd_mode <= 4'h3;
        upd_done <= 4'h7;
        rdc("live", 12'h050, 32'h0, 32'h1);
        apb(1'b1, 12'h008, 32'h4008);
        rdc("live", 12'h050, 32'h1, 32'h1);
        rdc("latched", 12'h058, 32'h1, 32'h1);
        upd_done <= 4'h6;
        pll_locked <= 3'h5;
        rdc("live", 12'h050, 32'h2, 32'h3);
        rdc("latched", 12'h058, 32'h3, 32'h3);
        apb(1'b1, 12'h058, 32'h1);
        rdc("latched_w1c", 12'h058, 32'h2, 32'h3);
        rdc("summary", 12'h040, 32'h0, 32'h1);
        apb(1'b1, 12'h060, 32'h2);
        rdc("summary", 12'h040, 32'h1, 32'h1);
        chk("int_n_o", 1'b0, int_n_o);
        // Clear on read, then the one-second tick
        // Request lowered after complete read high; timed-update mode keeps the request up
        apb(1'b1, 12'h008, 32'h4024);
        rdc("latched", 12'h058, 32'h2, 32'h3);
        chk("update_req_auto", 1'b1, pm_req);
        rdc("latched_cor", 12'h058, 32'h0, 32'h3);
        apb(1'b1, 12'h060, 32'h4);
        cyc(TICK + 5);
        rdc("summary", 12'h040, 32'h1, 32'h1);
        rdc("onesec", 12'h058, 32'h4, 32'h4);
        apb(1'b0, 12'h0C4, 32'h0);
        chk("pslverr", 1'b1, err_q);
        chk("unmapped", 32'h0, rd);
        tally_and_finish();
    end
endmodule // tb_top
